// file: logic/sdram_cmd_if.sv
`default_nettype none
interface sdram_cmd_if;
   // Command, bank and address lines driven by the controller
   sdram_mode_pkg::cmd_t cmd;
   logic [2:0]           ba;
   logic [12:0]          addr;

   modport ctrl (output cmd, output ba, output addr);
   modport dev  (input cmd, input ba, input addr);
endinterface : sdram_cmd_if
`default_nettype wire

// file: logic/sdram_mode_ctrl.sv
`default_nettype none
module sdram_mode_ctrl (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Request port
   input  wire logic        req_valid,
   input  wire logic [2:0]  req_kind,
   input  wire logic [2:0]  req_ba,
   input  wire logic [12:0] req_addr,
   output logic             req_done,
   output logic             req_refused,
   // Mode settings
   input  wire logic        cfg_burst8,
   input  wire logic        cfg_interleave,
   input  wire logic [2:0]  cfg_latency,
   input  wire logic        cfg_loop_reset,
   input  wire logic        cfg_slow_exit,
   input  wire logic [12:0] cfg_ext_word,
   input  wire logic        cfg_cal_default,
   // Command bus
   sdram_cmd_if.ctrl        bus
);
   // -----------------------------------------------------------
   // Request decode and pacing
   // -----------------------------------------------------------
   sdram_mode_pkg::cmd_t kind;
   logic [3:0]  mrd_cnt;       // Mode-set delay countdown
   logic [7:0]  lock_cnt;      // Loop lock countdown
   logic [5:0]  busy_cnt;      // Burst in progress
   logic        bank_open;     // Any row active
   logic [2:0]  al_shadow;     // Last additive latency written
   logic [12:0] mode_word;
   logic [12:0] ext_word;
   logic        allowed;

   assign kind = sdram_mode_pkg::cmd_t'(req_kind);
   // Every field supplied; test and reserved bits forced to zero
   assign mode_word = {cfg_slow_exit,
      3'(sdram_mode_pkg::WR_CYCLES - 1),
      cfg_loop_reset, 1'b0,
      (cfg_latency < 3'h3) ? 3'h3 : cfg_latency,
      cfg_interleave,
      cfg_burst8 ? sdram_mode_pkg::BL8_CODE : sdram_mode_pkg::BL4_CODE};
   assign ext_word = {cfg_ext_word[12:10],
      cfg_cal_default ? sdram_mode_pkg::CAL_DEFAULT : 3'h0,
      cfg_ext_word[6:0]};

   always_comb
   begin
      allowed = mrd_cnt == 4'h0;
      case (kind)
         sdram_mode_pkg::CMD_LOAD:
            allowed = allowed && !bank_open && busy_cnt == 6'h00;
         sdram_mode_pkg::CMD_READ:
            allowed = allowed && bank_open && busy_cnt == 6'h00
                      && lock_cnt == 8'h00;
         sdram_mode_pkg::CMD_WRITE, sdram_mode_pkg::CMD_WRITE_AP:
            allowed = allowed && bank_open && busy_cnt == 6'h00;
         sdram_mode_pkg::CMD_ACT:
            allowed = allowed && !bank_open;
         sdram_mode_pkg::CMD_PRE_ALL:
            allowed = allowed && busy_cnt == 6'h00;
         default:
            allowed = 1'b0;
      endcase
   end

   // -----------------------------------------------------------
   // Command issue; one cycle per command, NOP between
   // -----------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         bus.cmd     <= sdram_mode_pkg::CMD_NOP;
         bus.ba      <= 3'h0;
         bus.addr    <= 13'h0000;
         req_done    <= 1'b0;
         req_refused <= 1'b0;
      end
      else
      begin
         bus.cmd     <= sdram_mode_pkg::CMD_NOP;
         req_done    <= req_valid && allowed;
         req_refused <= req_valid && !allowed;
         if (req_valid && allowed)
         begin
            bus.cmd  <= kind;
            bus.ba   <= req_ba;
            bus.addr <= req_addr;
            if (kind == sdram_mode_pkg::CMD_LOAD)
            begin
               // Third bank bit and high bits stay zero
               bus.ba   <= {1'b0, req_ba[1:0]};
               bus.addr <= req_ba[1:0] == sdram_mode_pkg::SEL_MODE
                           ? mode_word : ext_word;
            end
         end
      end
   end

   // -----------------------------------------------------------
   // Pacing counters and bank tracking
   // -----------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         mrd_cnt   <= 4'h0;
         lock_cnt  <= 8'h00;
         busy_cnt  <= 6'h00;
         bank_open <= 1'b0;
         al_shadow <= 3'h0;
      end
      else
      begin
         if (mrd_cnt != 4'h0)
            mrd_cnt <= mrd_cnt - 4'h1;
         if (lock_cnt != 8'h00)
            lock_cnt <= lock_cnt - 8'h01;
         if (busy_cnt != 6'h00)
            busy_cnt <= busy_cnt - 6'h01;
         if (req_valid && allowed)
         begin
            case (kind)
               sdram_mode_pkg::CMD_LOAD:
               begin
                  mrd_cnt <= 4'(sdram_mode_pkg::MODE_SET_DELAY - 1);
                  if (req_ba[1:0] == sdram_mode_pkg::SEL_EXT)
                     al_shadow <= ext_word[sdram_mode_pkg::AL_LSB +: 3];
                  else if (cfg_loop_reset)
                     lock_cnt <= 8'(sdram_mode_pkg::LOOP_LOCK_CYCLES);
               end
               sdram_mode_pkg::CMD_ACT:
                  bank_open <= 1'b1;
               sdram_mode_pkg::CMD_PRE_ALL:
                  bank_open <= 1'b0;
               sdram_mode_pkg::CMD_READ, sdram_mode_pkg::CMD_WRITE:
                  busy_cnt <= 6'(al_shadow) + 6'h18;
               sdram_mode_pkg::CMD_WRITE_AP:
               begin
                  // Auto precharge: row marked closed at issue, before recovery
                  busy_cnt  <= 6'(al_shadow) + 6'h18;
                  bank_open <= 1'b0;
               end
               default:
                  busy_cnt <= busy_cnt;
            endcase
         end
      end
   end
endmodule : sdram_mode_ctrl
`default_nettype wire

// file: logic/sdram_mode_dev.sv
`default_nettype none
module sdram_mode_dev (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Command bus
   sdram_cmd_if.dev         bus,
   // Stored registers
   output logic [16:0]      mode_config_register,
   output logic [16:0]      extended_mode_config_register,
   // Status
   output logic             test_mode,
   output logic             loop_locked,
   output logic             slow_exit_sel,
   output logic [3:0]       total_read_latency,
   // Burst beats
   output logic             read_beat,
   output logic             write_beat,
   output logic [12:0]      beat_col,
   output logic             precharge_done
);
   // -----------------------------------------------------------
   // Decoded fields
   // -----------------------------------------------------------
   typedef enum logic [1:0] {DEV_IDLE, DEV_WAIT, DEV_BEATS, DEV_RECOVER}
      dev_state_t;
   dev_state_t  state;                // Burst sequencer
   logic [7:0]  lock_cnt;             // Loop lock countdown
   logic [3:0]  cnt;                  // Latency or recovery count
   logic [2:0]  beat;                 // Beat index in burst
   logic [12:0] col_base;             // Start column of burst
   logic        is_write;             // Burst direction
   logic        auto_pre;             // Write with auto precharge
   logic        len8;
   logic        inter;
   logic [3:0]  rl;
   logic [3:0]  wr;
   logic        load_mode;
   logic        load_ext;

   // Burst length code other than eight runs as four
   assign len8  = mode_config_register[sdram_mode_pkg::BL_LSB +: 3]
                  == sdram_mode_pkg::BL8_CODE;
   assign inter = mode_config_register[sdram_mode_pkg::BT_BIT];
   // Total latency is additive plus read latency
   assign rl = 4'(extended_mode_config_register[sdram_mode_pkg::AL_LSB +: 3])
             + sdram_mode_pkg::lat_of(
                  mode_config_register[sdram_mode_pkg::LAT_LSB +: 3]);
   assign wr = 4'(mode_config_register[sdram_mode_pkg::WR_LSB +: 3]) + 4'h1;
   // Bank bits pick the register being loaded
   assign load_mode = bus.cmd == sdram_mode_pkg::CMD_LOAD
                    && bus.ba[1:0] == sdram_mode_pkg::SEL_MODE;
   assign load_ext  = bus.cmd == sdram_mode_pkg::CMD_LOAD
                    && bus.ba[1:0] == sdram_mode_pkg::SEL_EXT;

   // -----------------------------------------------------------
   // Mode register load, test mode and loop reset self-clear
   // -----------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         mode_config_register <= sdram_mode_pkg::REG_RESET;
         test_mode            <= 1'b0;
      end
      else if (load_mode)
      begin
         // Test bit set: enter test mode, leave other fields alone
         test_mode <= bus.addr[sdram_mode_pkg::TM_BIT];
         if (!bus.addr[sdram_mode_pkg::TM_BIT])
            // A load writes every field at once
            mode_config_register <= {bus.ba[2], 3'h0, bus.addr};
      end
      else if (mode_config_register[sdram_mode_pkg::LOOP_RST_BIT])
         // Loop reset issued; the bit drops back to zero
         mode_config_register[sdram_mode_pkg::LOOP_RST_BIT] <= 1'b0;
   end

   // -----------------------------------------------------------
   // Extended register load
   // -----------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         extended_mode_config_register <= sdram_mode_pkg::REG_RESET;
      else if (load_ext)
         extended_mode_config_register <= {bus.ba[2], 3'h0, bus.addr};
   end

   // -----------------------------------------------------------
   // Loop lock timer; a fresh reset restarts it
   // -----------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         lock_cnt    <= 8'h00;
         loop_locked <= 1'b0;
      end
      else if (mode_config_register[sdram_mode_pkg::LOOP_RST_BIT])
      begin
         lock_cnt    <= 8'(sdram_mode_pkg::LOOP_LOCK_CYCLES - 1);
         loop_locked <= 1'b0;
      end
      else if (lock_cnt != 8'h00)
         lock_cnt <= lock_cnt - 8'h01;
      else
         loop_locked <= 1'b1;
   end

   // -----------------------------------------------------------
   // Status outputs
   // -----------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         slow_exit_sel      <= 1'b0;
         total_read_latency <= 4'h0;
      end
      else
      begin
         // Applies to active power-down only
         slow_exit_sel      <= mode_config_register[sdram_mode_pkg::PD_BIT];
         total_read_latency <= rl;
      end
   end

   // -----------------------------------------------------------
   // Burst sequencer. One burst at a time; commands arriving
   // while busy are dropped, as the controller never sends them.
   // -----------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state          <= DEV_IDLE;
         cnt            <= 4'h0;
         beat           <= 3'h0;
         col_base       <= 13'h0000;
         is_write       <= 1'b0;
         auto_pre       <= 1'b0;
         read_beat      <= 1'b0;
         write_beat     <= 1'b0;
         beat_col       <= 13'h0000;
         precharge_done <= 1'b0;
      end
      else
      begin
         read_beat      <= 1'b0;
         write_beat     <= 1'b0;
         precharge_done <= 1'b0;
         case (state)
            DEV_IDLE:
            begin
               if (bus.cmd == sdram_mode_pkg::CMD_READ)
               begin
                  // Held additive latency, then read latency
                  cnt      <= rl - 4'h1;
                  is_write <= 1'b0;
                  auto_pre <= 1'b0;
                  col_base <= bus.addr;
                  state    <= DEV_WAIT;
               end
               else if (bus.cmd == sdram_mode_pkg::CMD_WRITE
                        || bus.cmd == sdram_mode_pkg::CMD_WRITE_AP)
               begin
                  // Write latency is one below total read latency
                  cnt      <= rl - 4'h2;
                  is_write <= 1'b1;
                  auto_pre <= bus.cmd == sdram_mode_pkg::CMD_WRITE_AP;
                  col_base <= bus.addr;
                  state    <= DEV_WAIT;
               end
            end
            DEV_WAIT, DEV_BEATS:
            begin
               if (state == DEV_WAIT && cnt != 4'h0)
                  cnt <= cnt - 4'h1;
               else
               begin
                  // Block chosen by upper bits, wraps inside
                  beat_col <= {col_base[12:3],
                     len8 ? 1'b0 : col_base[2], 2'h0}
                     | 13'(sdram_mode_pkg::burst_offset(
                          {len8 & col_base[2], col_base[1:0]}, beat,
                          len8, inter));
                  read_beat  <= !is_write;
                  write_beat <= is_write;
                  beat       <= beat + 3'h1;
                  state      <= DEV_BEATS;
                  if (beat == (len8 ? 3'h7 : 3'h3))
                  begin
                     beat  <= 3'h0;
                     // Precharge waits recovery count after data
                     cnt   <= wr - 4'h1;
                     state <= auto_pre ? DEV_RECOVER : DEV_IDLE;
                  end
               end
            end
            DEV_RECOVER:
            begin
               if (cnt != 4'h0)
                  cnt <= cnt - 4'h1;
               else
               begin
                  precharge_done <= 1'b1;
                  state          <= DEV_IDLE;
               end
            end
            default:
               state <= DEV_IDLE;
         endcase
      end
   end
endmodule : sdram_mode_dev
`default_nettype wire

// file: logic/sdram_mode_pkg.sv
// Contract
// - Controller loads registers only with banks idle
// - Controller waits mode-set delay after every load
// - Each load writes every field; values persist
// - Loop reset bit starts reset, then self-clears
// - Controller waits 200 clocks after loop reset
// - Low three bits select burst of four/eight
// - Burst wraps inside block of burst length
// - Burst-type bit picks sequential or interleaved order
// - Length four: start plus i, or XOR i
// - Length eight: XOR order, or nibble-wrapped sequential
// - Test bit set writes nothing else; never used
// - Auto precharge waits write-recovery count after data
// - Controller rounds recovery time up; no reserved codes
// - Power-down bit picks fast or slow exit
// - Read latency field holds three to seven
// - First read data at command edge plus latency
// - Read held additive latency before executing
// - Extended register holds loop, drive, latency settings
// - Controller writes zeros above bit twelve
// - Calibration bits ones during init, then zeros
// - Bank bits pick register, address carries fields
// - Total latency additive plus read; write one less
`default_nettype none
package sdram_mode_pkg;
   // -----------------------------------------------------------
   // Commands on the shared command bus
   // -----------------------------------------------------------
   typedef enum logic [2:0] {
      CMD_NOP, CMD_LOAD, CMD_ACT, CMD_READ, CMD_WRITE, CMD_WRITE_AP,
      CMD_PRE_ALL
   } cmd_t;

   // -----------------------------------------------------------
   // Register selection and field layout
   // -----------------------------------------------------------
   localparam logic [1:0] SEL_MODE     = 2'h0;   // Bank bits select
   localparam logic [1:0] SEL_EXT      = 2'h1;
   localparam int         REG_W        = 17;
   localparam int         ADDR_W       = 13;
   localparam int         BL_LSB       = 0;      // Three bits
   localparam int         BT_BIT       = 3;
   localparam int         LAT_LSB      = 4;      // Three bits
   localparam int         TM_BIT       = 7;
   localparam int         LOOP_RST_BIT = 8;
   localparam int         WR_LSB       = 9;      // Three bits
   localparam int         PD_BIT       = 12;
   localparam int         AL_LSB       = 3;      // Extended, three bits
   localparam int         CAL_LSB      = 7;      // Extended, three bits
   localparam logic [2:0] BL4_CODE     = 3'h2;
   localparam logic [2:0] BL8_CODE     = 3'h3;
   localparam logic [2:0] CAL_DEFAULT  = 3'h7;
   localparam logic [16:0] REG_RESET   = 17'h00000;

   // -----------------------------------------------------------
   // Timing
   // -----------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 10;
   localparam int MODE_SET_DELAY   = 2;    // In clocks
   localparam int LOOP_LOCK_CYCLES = 200;
   localparam int WR_TIME_NS       = 15;
   localparam int WR_CYCLES        =
      (WR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Read latency code to clocks; reserved codes run as seven
   function automatic logic [3:0] lat_of(input logic [2:0] code);
      lat_of = (code >= 3'h3) ? {1'b0, code} : 4'h7;
   endfunction : lat_of

   // Beat offset within a burst block
   function automatic logic [2:0] burst_offset(
      input logic [2:0] start,
      input logic [2:0] beat,
      input logic       len8,
      input logic       inter
   );
      logic [1:0] low;
      low = start[1:0] + beat[1:0];
      if (inter)
         burst_offset = len8 ? (start ^ beat)
                             : {1'b0, start[1:0] ^ beat[1:0]};
      else
         burst_offset = len8 ? {start[2] ^ beat[2], low}
                             : {1'b0, low};
   endfunction : burst_offset
endpackage : sdram_mode_pkg
`default_nettype wire

// file: verif/sdram_mode_properties.sv
`default_nettype none
module sdram_mode_properties (
   // Clock and reset
   input wire logic                 sys_clk,
   input wire logic                 rst_n,
   // Command bus
   input wire sdram_mode_pkg::cmd_t cmd,
   input wire logic [2:0]           ba,
   input wire logic [12:0]          addr
);
   // ------------------------------------------------------------
   // Helper state
   // ------------------------------------------------------------
   logic       row_open;   // Any row open
   logic [8:0] lock_left;  // Clocks until reads may resume
   logic [4:0] burst_left; // Burst tail
   logic       mr_load;    // Mode register load

   assign mr_load = cmd == sdram_mode_pkg::CMD_LOAD
                    && ba[1:0] == sdram_mode_pkg::SEL_MODE;

   // Row tracking
   always_ff @(posedge sys_clk)
      if (!rst_n)
         row_open <= 1'b0;
      else if (cmd == sdram_mode_pkg::CMD_ACT)
         row_open <= 1'b1;
      else if (cmd == sdram_mode_pkg::CMD_PRE_ALL
               || cmd == sdram_mode_pkg::CMD_WRITE_AP)
         row_open <= 1'b0;

   // Loop lock wait
   always_ff @(posedge sys_clk)
      if (!rst_n)
         lock_left <= 9'h000;
      else if (mr_load && addr[sdram_mode_pkg::LOOP_RST_BIT])
         lock_left <= 9'(sdram_mode_pkg::LOOP_LOCK_CYCLES - 1);
      else if (lock_left != 9'h000)
         lock_left <= lock_left - 9'h001;

   // Burst in flight
   always_ff @(posedge sys_clk)
      if (!rst_n)
         burst_left <= 5'h00;
      else if (cmd inside {sdram_mode_pkg::CMD_READ,
               sdram_mode_pkg::CMD_WRITE, sdram_mode_pkg::CMD_WRITE_AP})
         burst_left <= 5'h15;
      else if (burst_left != 5'h00)
         burst_left <= burst_left - 5'h01;

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_load;
      cmd == sdram_mode_pkg::CMD_LOAD;
   endsequence
   sequence s_quiet;
      cmd == sdram_mode_pkg::CMD_NOP;
   endsequence

   AST_LOAD_GAP: assert property (s_load |=> s_quiet)
      else $error("command inside mode set delay");
   AST_LOAD_IDLE: assert property (s_load |-> !row_open && burst_left == 0)
      else $error("load with row open or burst busy");
   AST_NO_TEST: assert property (mr_load |-> !addr[7])
      else $error("test mode bit set");
   AST_BANK2_ZERO: assert property (s_load |-> !ba[2])
      else $error("reserved bank bit set");
   AST_WR_CODE: assert property (mr_load |-> addr[11:9] == 3'(sdram_mode_pkg::WR_CYCLES - 1))
      else $error("write recovery code wrong");
   AST_LOCK_WAIT: assert property (cmd == sdram_mode_pkg::CMD_READ |-> lock_left == 0)
      else $error("read before loop lock");
   AST_LEN_CODE: assert property (mr_load |-> addr[2:0] == 3'h2 || addr[2:0] == 3'h3)
      else $error("reserved burst length code");
   AST_LAT_CODE: assert property (mr_load |-> addr[6:4] >= 3'h3)
      else $error("reserved latency code");
endmodule : sdram_mode_properties
`default_nettype wire

// file: verif/sdram_mode_register_burst_cfg_tb.sv
`default_nettype none
module sdram_mode_register_burst_cfg_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        sys_clk, rst_n, req_valid, req_done, req_refused;
   logic [2:0]  req_kind, req_ba, cfg_latency;
   logic [12:0] req_addr, cfg_ext_word, beat_col, rd_start, wr_start;
   logic        cfg_burst8, cfg_interleave, cfg_loop_reset;
   logic        cfg_slow_exit, cfg_cal_default, test_mode, loop_locked;
   logic        slow_exit_sel, read_beat, write_beat, precharge_done;
   logic [16:0] mode_config_register, extended_mode_config_register;
   logic [3:0]  total_read_latency;
   logic [31:0] lfsr = 32'h000143F7; // Fixed seed
   int failures, n_tests, cyc, rd_edge, wr_edge, rd_n, wr_n, last_wr, rl_exp;

   sdram_cmd_if bus ();
   sdram_mode_ctrl u_sdram_mode_ctrl (.sys_clk, .rst_n, .req_valid,
      .req_kind, .req_ba, .req_addr, .req_done, .req_refused,
      .cfg_burst8, .cfg_interleave, .cfg_latency, .cfg_loop_reset,
      .cfg_slow_exit, .cfg_ext_word, .cfg_cal_default, .bus);
   sdram_mode_dev u_sdram_mode_dev (.sys_clk, .rst_n, .bus,
      .mode_config_register, .extended_mode_config_register, .test_mode,
      .loop_locked, .slow_exit_sel, .total_read_latency, .read_beat,
      .write_beat, .beat_col, .precharge_done);
   sdram_mode_properties u_sdram_mode_properties (.sys_clk, .rst_n,
      .cmd(bus.cmd), .ba(bus.ba), .addr(bus.addr));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize

   // Shift register step
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next_rand

   // Expected column of beat i
   function automatic logic [12:0] exp_col(input logic [12:0] s,
                                           input int i);
      logic [2:0] b;
      b = 3'(i);
      if (cfg_burst8)
         exp_col = {s[12:3], cfg_interleave ? s[2:0] ^ b
                    : {s[2] ^ b[2], s[1:0] + b[1:0]}};
      else
         exp_col = {s[12:2], cfg_interleave ? s[1:0] ^ b[1:0]
                    : s[1:0] + b[1:0]};
   endfunction : exp_col

   // Mode word, loop reset bit cleared
   function automatic logic [16:0] mr_exp();
      mr_exp = {4'h0, cfg_slow_exit, 3'(sdram_mode_pkg::WR_CYCLES - 1),
                2'h0, (cfg_latency < 3'h3) ? 3'h3 : cfg_latency,
                cfg_interleave, cfg_burst8 ? 3'h3 : 3'h2};
   endfunction : mr_exp

   function automatic logic [16:0] emr_exp();
      emr_exp = {4'h0, cfg_ext_word[12:10],
                 cfg_cal_default ? 3'h7 : 3'h0, cfg_ext_word[6:0]};
   endfunction : emr_exp

   // One request; ok when issued
   task automatic request(input sdram_mode_pkg::cmd_t kind,
                          input logic [2:0] bank,
                          input logic [12:0] col, output logic ok);
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_kind  <= kind;
      req_ba    <= bank;
      req_addr  <= col;
      @(posedge sys_clk);
      req_valid <= 1'b0;
      #1;
      ok = req_done === 1'b1;
      check("one answer", req_done + req_refused, 1);
   endtask : request

   // Load both registers, check them
   task automatic load_both();
      logic ok;
      request(sdram_mode_pkg::CMD_LOAD, 3'h0, 13'h0000, ok);
      check("mode load", ok, 1);
      request(sdram_mode_pkg::CMD_LOAD, 3'h1, 13'h0000, ok);
      check("ext load", ok, 1);
      repeat (3) @(posedge sys_clk);
      #1;
      rl_exp = int'(cfg_ext_word[5:3]) + int'(mr_exp() >> 4) % 8;
      check("mode reg", mode_config_register, mr_exp());
      check("ext reg", extended_mode_config_register, emr_exp());
      check("total latency", total_read_latency, rl_exp);
      check("slow exit", slow_exit_sel, cfg_slow_exit);
      check("test mode", test_mode, 0);
   endtask : load_both

   // ------------------------------------------------------------
   // Beat monitor
   // ------------------------------------------------------------
   always @(posedge sys_clk)
   begin
      cyc++;
      if (read_beat === 1'b1)
      begin
         check("read time", cyc - rd_edge, rl_exp + 1 + rd_n);
         check("read col", beat_col, exp_col(rd_start, rd_n));
         rd_n++;
      end
      if (write_beat === 1'b1)
      begin
         check("write time", cyc - wr_edge, rl_exp + wr_n);
         check("write col", beat_col, exp_col(wr_start, wr_n));
         wr_n++;
         last_wr = cyc;
      end
      if (precharge_done === 1'b1)
         check("recovery", cyc - last_wr, sdram_mode_pkg::WR_CYCLES);
      if (bus.cmd === sdram_mode_pkg::CMD_READ)
      begin
         rd_edge = cyc;
         rd_start = bus.addr;
         rd_n = 0;
      end
      if (bus.cmd === sdram_mode_pkg::CMD_WRITE_AP)
      begin
         wr_edge = cyc;
         wr_start = bus.addr;
         wr_n = 0;
      end
   end

   // ------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ------------------------------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Ten passes of ~100 clocks plus lock wait
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      summarize();
   end

   initial
   begin
      logic ok;
      logic [12:0] col;
      {rst_n, req_valid, req_kind, req_ba, req_addr} = '0;
      {cfg_burst8, cfg_interleave, cfg_latency, cfg_loop_reset,
       cfg_slow_exit, cfg_ext_word} = '0;
      cfg_cal_default = 1'b1;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      // Corner: loop reset, clamp, calibration
      cfg_loop_reset <= 1'b1;
      cfg_slow_exit  <= 1'b1;
      load_both();
      check("locked early", loop_locked, 0);
      request(sdram_mode_pkg::CMD_ACT, 3'h0, 13'h0000, ok);
      repeat (4) @(posedge sys_clk);
      request(sdram_mode_pkg::CMD_READ, 3'h0, 13'h0005, ok);
      check("read in lock", ok, 0);
      request(sdram_mode_pkg::CMD_LOAD, 3'h0, 13'h0000, ok);
      check("load row open", ok, 0);
      for (int i = 0; i < 300 && loop_locked !== 1'b1; i++)
         @(posedge sys_clk);
      check("locked", loop_locked, 1);
      request(sdram_mode_pkg::CMD_PRE_ALL, 3'h0, 13'h0000, ok);
      cfg_loop_reset <= 1'b0;
      cfg_cal_default <= 1'b0;
      // Random passes
      for (int k = 0; k < 10; k++)
      begin
         lfsr = next_rand(next_rand(lfsr));
         cfg_burst8     <= lfsr[0] | (k == 0);
         cfg_interleave <= lfsr[1];
         cfg_latency    <= 3'h3 + 3'(lfsr[4:2] % 5);
         cfg_slow_exit  <= lfsr[5];
         cfg_ext_word   <= {lfsr[18:16], 3'h0, lfsr[19],
                            3'(lfsr[8:6] % 7), lfsr[22:20]};
         load_both();
         request(sdram_mode_pkg::CMD_ACT, 3'h0, 13'h0000, ok);
         repeat (4) @(posedge sys_clk);
         col = {5'h00, lfsr[31:30] ^ lfsr[9:8], lfsr[29:24]};
         request(sdram_mode_pkg::CMD_READ, 3'h0, col, ok);
         check("read ok", ok, 1);
         repeat (40) @(posedge sys_clk);
         check("read beats", rd_n, cfg_burst8 ? 8 : 4);
         request(sdram_mode_pkg::CMD_WRITE_AP, 3'h0, col ^ 13'h0003, ok);
         check("write ok", ok, 1);
         repeat (40) @(posedge sys_clk);
         check("write beats", wr_n, cfg_burst8 ? 8 : 4);
      end
      summarize();
   end
endmodule : sdram_mode_register_burst_cfg_tb
`default_nettype wire
